/* File: ouv_check_if.sv */
// Purpose: carries write data and stored limits to the range checker
// Assumes: one clock domain, purely combinational checker
// Notes: monitor drives operands, checker returns verdicts
`timescale 1ns/10ps
`default_nettype none
interface ouv_check_if;
    logic [15:0] wrData;
    logic [15:0] voutCommand;
    logic [7:0]  scaleLoop;
    logic [15:0] warnQ;
    logic [15:0] faultQ;
    logic [15:0] nvmFault;
    logic        warnOk;
    logic        faultOk;
    logic        actionOk;
    logic [15:0] warnDefault;
    modport mon (output wrData, voutCommand, scaleLoop, warnQ, faultQ, nvmFault,
                 input warnOk, faultOk, actionOk, warnDefault);
    modport chk (input wrData, voutCommand, scaleLoop, warnQ, faultQ, nvmFault,
                 output warnOk, faultOk, actionOk, warnDefault);
endinterface
`default_nettype wire

/* File: ouv_host.sv */
// Purpose: management host model that issues commands to the monitor
// Assumes: commands start on a falling edge and are taken on the next rising edge
// Notes: write data is inverted once released so a stale value is never seen
`timescale 1ns/10ps
`default_nettype none
module ouv_host (
    // clock
    input  wire logic        mclk,
    // command side
    output var  logic        cmdValid,
    output var  logic        cmdWrite,
    output var  logic [7:0]  cmdCode,
    output var  logic [15:0] cmdWrData,
    input  wire logic [15:0] cmdRdData,
    input  wire logic        cmdRdValid
);
    // idle bus at time zero
    initial
    begin
        cmdValid  = 1'b0;
        cmdWrite  = 1'b0;
        cmdCode   = 8'h00;
        cmdWrData = 16'h0000;
    end

    // one command: held over one rising edge, answer taken at the next falling edge
    task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                        output logic [15:0] rd, output logic v);
        @(negedge mclk);
        cmdValid  = 1'b1;
        cmdWrite  = w;
        cmdCode   = c;
        cmdWrData = d;
        @(negedge mclk);
        cmdValid  = 1'b0;
        cmdWrData = ~d;
        rd        = cmdRdData;
        v         = cmdRdValid;
    endtask
endmodule
`default_nettype wire

/* File: ouv_limit_check.sv */
// Purpose: range checks for threshold writes and default warning derivation
// Assumes: scale factor of zero is treated as one
// Notes: combinational only
`timescale 1ns/10ps
`default_nettype none
module ouv_limit_check
    import ouv_pkg::*;
(
    // operands and verdicts
    ouv_check_if.chk ck
);
    logic [7:0]  scale;
    logic [15:0] mant;
    logic [23:0] scaled;
    logic [15:0] cand;

    // verdicts against the currently stored values
    always_comb
    begin
        scale = (ck.scaleLoop == 8'h00) ? 8'h01 : ck.scaleLoop;
        mant = ck.wrData & MANT_MASK;
        scaled = 24'(mant) * 24'(scale);         // widen first so no product bits are lost
        ck.warnOk = (mant > ck.faultQ) && (mant < ck.voutCommand)
                    && (scaled > WARN_SCALED_LO) && (scaled < WARN_SCALED_HI);
        ck.faultOk = (mant == 16'h0000)
                     || ((scaled > FAULT_SCALED_LO) && (mant < ck.warnQ));
        ck.actionOk = (ck.wrData[ACT_RETRY_MSB:ACT_RETRY_LSB] == RETRY_LATCH)
                      || (ck.wrData[ACT_RETRY_MSB:ACT_RETRY_LSB] == RETRY_CONT);
        cand = 16'(ck.nvmFault + (ck.nvmFault >> DEFAULT_SHIFT));
        if (ck.nvmFault == 16'h0000)
            ck.warnDefault = WARN_MIN_NUM / {8'h00, scale};
        else if (cand < ck.voutCommand)
            ck.warnDefault = cand & MANT_MASK;
        else
            ck.warnDefault = 16'((ck.nvmFault & NVM_KEEP_MASK) + ONE_LSB);
    end
endmodule
`default_nettype wire

/* File: ouv_monitor.sv */
// Purpose: undervoltage thresholds, fault action and detection for a converter
// Assumes: voltages are mantissas on the same scale as the thresholds
// Notes: command port stands for the management bus command layer
`timescale 1ns/10ps
`default_nettype none
module ouv_monitor
    import ouv_pkg::*;
#(
    parameter int unsigned RAMP_CYCLES = RAMP_CYCLES_DFLT
)(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        ce,
    // command port
    input  wire logic        cmdValid,
    input  wire logic        cmdWrite,
    input  wire logic [7:0]  cmdCode,
    input  wire logic [15:0] cmdWrData,
    output var  logic [15:0] cmdRdData,
    output var  logic        cmdRdValid,
    // non-volatile store and restore
    input  wire logic        storeAll,
    input  wire logic        loadDefaults,
    input  wire logic [15:0] nvmFaultIn,
    input  wire logic [7:0]  nvmActionIn,
    output var  logic        nvmStore,
    output var  logic [15:0] nvmFaultOut,
    output var  logic [7:0]  nvmActionOut,
    // converter state
    input  wire logic        converterEnable,
    input  wire logic [15:0] voutMeas,
    input  wire logic [15:0] voutCommand,
    input  wire logic [7:0]  scaleLoop,
    input  wire logic        rampLimitHit,
    input  wire logic        clearFaults,
    // status and control
    output var  logic        commFlag,
    output var  logic        invalidDataFlag,
    output var  logic        otherFlag,
    output var  logic        voltageFlag,
    output var  logic        uvWarnFlag,
    output var  logic        uvFaultFlag,
    output var  logic        rampTimeoutFault,
    output var  logic        smbAlert,
    output logic             powerStageOn
);
    ouv_check_if ck ();
    ouv_limit_check u_check (.ck(ck));

    logic [15:0] warnQ, warnD, faultQ, faultD;
    logic        ignoreQ, ignoreD, retryQ, retryD;
    logic        reachedQ, reachedD;
    logic        commQ, commD, invQ, invD, othQ, othD, voltQ, voltD;
    logic        uwQ, uwD, ufQ, ufD, rtQ, rtD, alertQ, alertD;
    logic [15:0] rdQ, rdD;
    logic        rdvQ, rdvD, stQ, stD;
    logic [15:0] nfQ, nfD;
    logic [7:0]  naQ, naD;
    ouv_state_t  stateQ, stateD;
    logic [31:0] cntQ, cntD;
    logic        wr, reject, warnHit, faultHit, rampHit;
    logic [7:0]  actionRd;

    assign ck.wrData      = cmdWrData;
    assign ck.voutCommand = voutCommand;
    assign ck.scaleLoop   = scaleLoop;
    assign ck.warnQ       = warnQ;
    assign ck.faultQ      = faultQ;
    assign ck.nvmFault    = nvmFaultIn & NVM_KEEP_MASK;

    // action register view: delay code hard-wired, retry bits mirror one store
    assign actionRd = {ignoreQ, 1'b0, {3{retryQ}}, ACT_DELAY_CODE};

    // detection: warning and fault masked until the setpoint was reached while enabled, ramp timeout only before
    always_comb
    begin
        wr = cmdValid && cmdWrite;
        reject = wr && (((cmdCode == CMD_UV_WARN) && !ck.warnOk)
                 || ((cmdCode == CMD_UV_FAULT) && !ck.faultOk)
                 || ((cmdCode == CMD_UV_ACTION) && !ck.actionOk));
        warnHit = reachedQ && converterEnable && (voutMeas < warnQ);
        faultHit = reachedQ && converterEnable && (faultQ != 16'h0000)
                   && (voutMeas < faultQ) && (stateQ == ST_RUN);
        rampHit = converterEnable && !reachedQ && rampLimitHit
                  && (stateQ == ST_RUN);
    end

    // configuration registers
    always_comb
    begin
        warnD = warnQ;
        faultD = faultQ;
        ignoreD = ignoreQ;
        retryD = retryQ;
        if (loadDefaults)
        begin
            faultD = nvmFaultIn & NVM_KEEP_MASK;
            warnD = ck.warnDefault;
            ignoreD = nvmActionIn[ACT_IGNORE_BIT];
            retryD = nvmActionIn[ACT_RETRY_MSB];
        end
        else if (wr && !reject)
        begin
            case (cmdCode)
                CMD_UV_WARN:   warnD = cmdWrData & MANT_MASK;
                CMD_UV_FAULT:  faultD = cmdWrData & MANT_MASK;
                CMD_UV_ACTION:
                begin
                    ignoreD = cmdWrData[ACT_IGNORE_BIT];
                    retryD = cmdWrData[ACT_RETRY_MSB];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            warnQ <= WARN_RST;
            faultQ <= FAULT_RST;
            ignoreQ <= ACTION_RST[ACT_IGNORE_BIT];
            retryQ <= ACTION_RST[ACT_RETRY_MSB];
        end
        else if (ce)
        begin
            warnQ <= warnD;
            faultQ <= faultD;
            ignoreQ <= ignoreD;
            retryQ <= retryD;
        end
    end

    // status flags: a new event wins over a clear in the same cycle
    always_comb
    begin
        commD = (commQ && !clearFaults) || reject;
        invD = (invQ && !clearFaults) || reject;
        othD = (othQ && !clearFaults) || warnHit || faultHit;
        voltD = (voltQ && !clearFaults) || warnHit || faultHit;
        uwD = (uwQ && !clearFaults) || warnHit;
        ufD = (ufQ && !clearFaults) || faultHit;
        rtD = (rtQ && !clearFaults) || rampHit;
        alertD = commD || othD || rtD;
        reachedD = converterEnable && (stateQ == ST_RUN)
                   && (reachedQ || (voutMeas >= voutCommand));
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            {commQ, invQ, othQ, voltQ, uwQ, ufQ, rtQ, alertQ} <= 8'h00;
            reachedQ <= 1'b0;
        end
        else if (ce)
        begin
            {commQ, invQ, othQ, voltQ, uwQ, ufQ, rtQ, alertQ} <=
                {commD, invD, othD, voltD, uwD, ufD, rtD, alertD};
            reachedQ <= reachedD;
        end
    end

    // fault action sequencer
    always_comb
    begin
        stateD = stateQ;
        cntD = cntQ;
        case (stateQ)
            ST_RUN:
                if (faultHit && ignoreQ)
                    stateD = ST_SHUT;
            ST_SHUT:
            begin
                cntD = 32'h0;
                stateD = retryQ ? ST_WAIT : ST_LATCH;
            end
            ST_WAIT:
                if (cntQ >= 32'(RESTART_RAMPS * RAMP_CYCLES) - 32'h1)
                    stateD = ST_RUN;
                else
                    cntD = 32'(cntQ + 32'h1);
            ST_LATCH:
                if (clearFaults)
                    stateD = ST_RUN;
            default: stateD = ST_RUN;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            stateQ <= ST_RUN;
            cntQ <= 32'h0;
        end
        else if (ce)
        begin
            stateQ <= stateD;
            cntQ <= cntD;
        end
    end

    // read-back and non-volatile save
    always_comb
    begin
        rdD = rdQ;
        rdvD = cmdValid && !cmdWrite;
        if (cmdValid && !cmdWrite)
        begin
            case (cmdCode)
                CMD_UV_WARN:   rdD = warnQ;
                CMD_UV_FAULT:  rdD = faultQ;
                CMD_UV_ACTION: rdD = {8'h00, actionRd};
                default:       rdD = 16'h0000;
            endcase
        end
        stD = storeAll;
        nfD = storeAll ? (faultQ & NVM_KEEP_MASK) : nfQ;
        naD = storeAll ? actionRd : naQ;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            rdQ <= 16'h0000;
            rdvQ <= 1'b0;
            stQ <= 1'b0;
            nfQ <= 16'h0000;
            naQ <= 8'h00;
        end
        else if (ce)
        begin
            rdQ <= rdD;
            rdvQ <= rdvD;
            stQ <= stD;
            nfQ <= nfD;
            naQ <= naD;
        end
    end

    assign cmdRdData        = rdQ;
    assign cmdRdValid       = rdvQ;
    assign nvmStore         = stQ;
    assign nvmFaultOut      = nfQ;
    assign nvmActionOut     = naQ;
    assign commFlag         = commQ;
    assign invalidDataFlag  = invQ;
    assign otherFlag        = othQ;
    assign voltageFlag      = voltQ;
    assign uvWarnFlag       = uwQ;
    assign uvFaultFlag      = ufQ;
    assign rampTimeoutFault = rtQ;
    assign smbAlert         = alertQ;
    assign powerStageOn     = (stateQ == ST_RUN);

    // checks
    warn_reject_a: assert property (@(posedge mclk) disable iff (rst)
        ce && wr && cmdCode == CMD_UV_WARN && !ck.warnOk && !loadDefaults
        |=> $stable(warnQ) && commQ && invQ && smbAlert)
        else $error("rejected warning write changed value or missed flags");
    warn_mask_a: assert property (@(posedge mclk) disable iff (rst)
        !reachedQ |=> !$rose(uwQ))
        else $error("warning flagged before setpoint reached");
    fault_off_a: assert property (@(posedge mclk) disable iff (rst)
        faultQ == 16'h0000 && !ufQ |=> !ufQ)
        else $error("fault flagged with fault checking off");
    fault_flags_a: assert property (@(posedge mclk) disable iff (rst)
        ce && faultHit |=> ufQ && othQ && voltQ && smbAlert)
        else $error("fault event missed status flags");
    action_bits_a: assert property (@(posedge mclk) disable iff (rst)
        ce && cmdValid && !cmdWrite && cmdCode == CMD_UV_ACTION
        |=> cmdRdData[2:0] == ACT_DELAY_CODE)
        else $error("action delay bits not reading seven");
    nvm_drop_a: assert property (@(posedge mclk) disable iff (rst)
        ce && storeAll |=> nvmStore && nvmFaultOut == ($past(faultQ) & NVM_KEEP_MASK))
        else $error("saved fault threshold kept low bits");
    ignore_run_a: assert property (@(posedge mclk) disable iff (rst)
        ce && faultHit && !ignoreQ |=> powerStageOn)
        else $error("ignore mode shut the converter down");
    latch_hold_a: assert property (@(posedge mclk) disable iff (rst)
        stateQ == ST_LATCH && !clearFaults |=> stateQ == ST_LATCH)
        else $error("latched-off state left without clear");
    ramp_swap_a: assert property (@(posedge mclk) disable iff (rst)
        ce && rampHit |=> rampTimeoutFault && stateQ == ST_RUN)
        else $error("ramp timeout missed or ran undervoltage action");
    fault_reject_a: assert property (@(posedge mclk) disable iff (rst)
        ce && wr && cmdCode == CMD_UV_FAULT && !ck.faultOk && !loadDefaults
        |=> $stable(faultQ) && commQ && invQ && smbAlert)
        else $error("rejected fault write changed value or missed flags");
    action_reject_a: assert property (@(posedge mclk) disable iff (rst)
        ce && wr && cmdCode == CMD_UV_ACTION && !ck.actionOk && !loadDefaults
        |=> $stable(ignoreQ) && $stable(retryQ) && commQ && invQ && smbAlert)
        else $error("rejected action write changed value or missed flags");
    warn_flags_a: assert property (@(posedge mclk) disable iff (rst)
        ce && warnHit |=> uwQ && othQ && voltQ && smbAlert)
        else $error("warning event missed status flags");
    fault_mask_a: assert property (@(posedge mclk) disable iff (rst)
        !reachedQ |=> !$rose(ufQ))
        else $error("fault flagged before setpoint reached");
endmodule
`default_nettype wire

/* File: ouv_pkg.sv */
// Purpose: constants for the output undervoltage monitor
// Assumes: thresholds are 12-bit mantissas, exponent fixed in the mode setting
// Notes:
// Contract
// - warning masked until setpoint reached, or disabled
// - bad warning write: keep value, flag, alert
// - warning above fault, below setpoint, scaled window
// - warning sets other, voltage, warning flags, alert
// - fixed exponent; only mantissa bits writable
// - default warning is fault plus fault/16
// - else rounded fault plus one LSB
// - zero fault: default warning 179/scale
// - fault masked until setpoint reached, or disabled
// - fault above 176/scale and below warning
// - zero fault disables fault checking only
// - saved fault threshold loses low four bits
// - ramp timeout replaces undervoltage fault action
// - fault sets other, voltage, fault flags, alert
// - action low bits read 7; default restart
// - action register saved on save-all
// - ignore bit 0 runs on; 1 shuts down
// - retry 000 latches, 111 restarts, else reject
`default_nettype none
package ouv_pkg;
    localparam logic [7:0]  CMD_UV_WARN    = 8'h43;
    localparam logic [7:0]  CMD_UV_FAULT   = 8'h44;
    localparam logic [7:0]  CMD_UV_ACTION  = 8'h45;
    localparam logic [15:0] MANT_MASK      = 16'h0fff;
    localparam logic [15:0] WARN_RST       = 16'h0143;
    localparam logic [15:0] FAULT_RST      = 16'h0130;
    localparam logic [7:0]  ACTION_RST     = 8'hbf;
    localparam logic [15:0] NVM_KEEP_MASK  = 16'hfff0;
    localparam logic [15:0] ONE_LSB        = 16'h0001;
    localparam logic [23:0] WARN_SCALED_LO = 24'h0000b2;
    localparam logic [23:0] WARN_SCALED_HI = 24'h0002dc;
    localparam logic [23:0] FAULT_SCALED_LO = 24'h0000b0;
    localparam logic [15:0] WARN_MIN_NUM   = 16'h00b3;
    localparam int          DEFAULT_SHIFT  = 4;
    localparam int          ACT_IGNORE_BIT = 7;
    localparam int          ACT_RETRY_MSB  = 5;
    localparam int          ACT_RETRY_LSB  = 3;
    localparam logic [2:0]  ACT_DELAY_CODE = 3'h7;
    localparam logic [2:0]  RETRY_LATCH    = 3'h0;
    localparam logic [2:0]  RETRY_CONT     = 3'h7;
    localparam int          RESTART_RAMPS  = 7;
    localparam int          CLK_PERIOD_NS  = 40;
    localparam int          RAMP_TIME_NS   = 1000000;
    localparam int          RAMP_CYCLES_DFLT = RAMP_TIME_NS / CLK_PERIOD_NS;
    typedef enum logic [3:0] {
        ST_RUN   = 4'h1,
        ST_SHUT  = 4'h2,
        ST_WAIT  = 4'h4,
        ST_LATCH = 4'h8
    } ouv_state_t;
endpackage
`default_nettype wire

/* File: test_ouv_monitor.sv */
// Purpose: self-checking bench for the undervoltage monitor
// Assumes: RAMP_CYCLES of 4, scale factor 1 unless a table entry or the zero-fault default check says otherwise
// Notes: inputs change on the falling edge only
`timescale 1ns/10ps
`default_nettype none
module test_ouv_monitor;
    typedef struct {logic [7:0] c; logic [7:0] s; logic [15:0] d; logic [15:0] e; logic ok;} ouv_ent_t;
    logic mclk, rst, ce, storeAll, loadDefaults, converterEnable, rampLimitHit, clearFaults;
    logic cmdValid, cmdWrite, cmdRdValid, nvmStore, commFlag, invalidDataFlag, otherFlag;
    logic voltageFlag, uvWarnFlag, uvFaultFlag, rampTimeoutFault, smbAlert, powerStageOn;
    logic [7:0]  cmdCode, nvmActionIn, nvmActionOut, scaleLoop;
    logic [15:0] cmdWrData, cmdRdData, nvmFaultIn, nvmFaultOut, voutMeas, voutCommand, rdv;
    logic        vld;
    int          err_total, cmp_count, cycCnt, i;
    ouv_ent_t    tbl [15];

    ouv_monitor #(.RAMP_CYCLES(4)) ouv_monitor_inst (.mclk(mclk), .rst(rst), .ce(ce),
        .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWrData(cmdWrData),
        .cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid), .storeAll(storeAll),
        .loadDefaults(loadDefaults), .nvmFaultIn(nvmFaultIn), .nvmActionIn(nvmActionIn),
        .nvmStore(nvmStore), .nvmFaultOut(nvmFaultOut), .nvmActionOut(nvmActionOut),
        .converterEnable(converterEnable), .voutMeas(voutMeas), .voutCommand(voutCommand),
        .scaleLoop(scaleLoop), .rampLimitHit(rampLimitHit), .clearFaults(clearFaults),
        .commFlag(commFlag), .invalidDataFlag(invalidDataFlag), .otherFlag(otherFlag),
        .voltageFlag(voltageFlag), .uvWarnFlag(uvWarnFlag), .uvFaultFlag(uvFaultFlag),
        .rampTimeoutFault(rampTimeoutFault), .smbAlert(smbAlert), .powerStageOn(powerStageOn));
    ouv_host ouv_host_inst (.mclk(mclk), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
        .cmdCode(cmdCode), .cmdWrData(cmdWrData), .cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid));

    // 25 MHz clock
    always #20 mclk = ~mclk;

    // hang guard, far above the few hundred cycles the tests need
    always @(posedge mclk)
    begin
        cycCnt++;
        if (cycCnt == 5000)
        begin
            err_total++;
            $display("wrong value at %0t: run did not finish", $time);
            end_sim();
        end
    end

    task automatic chkv(input logic [15:0] got, input logic [15:0] exp, input string m);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask

    task automatic chkb(input logic got, input logic exp, input string m);
        chkv({15'h0000, got}, {15'h0000, exp}, m);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        ouv_host_inst.xfer(1'b1, c, d, rdv, vld);
    endtask

    task automatic rdc(input logic [7:0] c, input logic [15:0] e);
        ouv_host_inst.xfer(1'b0, c, 16'h0000, rdv, vld);
        chkb(vld, 1'b1, "read strobe");
        chkv(rdv, e, "read data");
    endtask

    task automatic clr();
        clearFaults = 1'b1;
        cyc(1);
        clearFaults = 1'b0;
        cyc(1);
    endtask

    task automatic ldd(input logic [15:0] f);
        nvmFaultIn   = f;
        loadDefaults = 1'b1;
        cyc(1);
        loadDefaults = 1'b0;
        cyc(1);
    endtask

    // fall to the undervoltage level after the setpoint was reached
    task automatic dip();
        converterEnable = 1'b1;
        voutMeas        = 16'h0190;
        cyc(2);
        voutMeas        = 16'h0100;
        cyc(2);
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // write table: code, scale, data, expected read-back, accepted
    initial
    begin
        tbl = '{'{8'h43, 8'h01, 16'h0130, 16'h0143, 1'b0}, '{8'h43, 8'h01, 16'h0190, 16'h0143, 1'b0},
                '{8'h43, 8'h02, 16'h016e, 16'h0143, 1'b0}, '{8'h43, 8'h02, 16'h016d, 16'h016d, 1'b1},
                '{8'h43, 8'h01, 16'hf131, 16'h0131, 1'b1}, '{8'h44, 8'h01, 16'h00b0, 16'h0130, 1'b0},
                '{8'h44, 8'h01, 16'h0131, 16'h0130, 1'b0}, '{8'h44, 8'h01, 16'h00b1, 16'h00b1, 1'b1},
                '{8'h44, 8'h01, 16'h0000, 16'h0000, 1'b1}, '{8'h45, 8'h01, 16'h0000, 16'h0007, 1'b1},
                '{8'h45, 8'h01, 16'h00a8, 16'h0007, 1'b0}, '{8'h45, 8'h01, 16'h0080, 16'h0087, 1'b1},
                '{8'h45, 8'h01, 16'h0038, 16'h003f, 1'b1}, '{8'h45, 8'h01, 16'h00bf, 16'h00bf, 1'b1},
                '{8'h43, 8'hce, 16'h0140, 16'h0131, 1'b0}};
        // clock low, enable and reset high, every strobe and level low
        {mclk, ce, rst, storeAll, loadDefaults, converterEnable, rampLimitHit} = 7'h30;
        {clearFaults, err_total, cmp_count, cycCnt} = '0;
        {nvmFaultIn, voutMeas, voutCommand} = {16'h0130, 16'h0000, 16'h0190};
        {nvmActionIn, scaleLoop} = {8'hbf, 8'h01};
        cyc(20);
        rst = 1'b0;
        // reset values, fixed low bits and an unmapped code
        rdc(8'h43, 16'h0143);
        rdc(8'h44, 16'h0130);
        rdc(8'h45, 16'h00bf);
        rdc(8'h46, 16'h0000);
        $display("test reset values done");
        // limit checks, accepted and refused writes
        for (i = 0; i < 15; i++)
        begin
            scaleLoop = tbl[i].s;
            wr(tbl[i].c, tbl[i].d);
            rdc(tbl[i].c, tbl[i].e);
            chkb(commFlag, !tbl[i].ok, "comm flag");
            chkb(invalidDataFlag, !tbl[i].ok, "invalid flag");
            chkb(smbAlert, !tbl[i].ok, "alert");
            clr();
        end
        scaleLoop = 8'h01;
        $display("test write checks done");
        // default derivation from the stored fault value
        ldd(16'h0135);
        rdc(8'h44, 16'h0130);
        rdc(8'h43, 16'h0143);
        voutCommand = 16'h0140;
        ldd(16'h0130);
        rdc(8'h43, 16'h0131);
        ldd(16'h0000);
        rdc(8'h43, 16'h00b3);
        scaleLoop = 8'h02;
        ldd(16'h0000);
        rdc(8'h43, 16'h0059);
        scaleLoop = 8'h01;
        voutCommand = 16'h0190;
        ldd(16'h0130);
        $display("test defaults done");
        // masked before the setpoint is reached; ramp timeout instead
        converterEnable = 1'b1;
        voutMeas        = 16'h0100;
        cyc(4);
        chkb(uvWarnFlag, 1'b0, "warn masked");
        chkb(uvFaultFlag, 1'b0, "fault masked");
        rampLimitHit = 1'b1;
        cyc(2);
        chkb(rampTimeoutFault, 1'b1, "ramp fault");
        chkb(uvFaultFlag, 1'b0, "no uv fault");
        chkb(powerStageOn, 1'b1, "still on");
        rampLimitHit = 1'b0;
        converterEnable = 1'b0;
        clr();
        // warning then fault with restart after seven ramps
        converterEnable = 1'b1;
        voutMeas        = 16'h0190;
        cyc(2);
        voutMeas = 16'h0138;
        cyc(2);
        chkv({uvWarnFlag, otherFlag, voltageFlag, smbAlert, uvFaultFlag}, 16'h001e, "warn");
        voutMeas = 16'h0100;
        cyc(2);
        chkb(uvFaultFlag, 1'b1, "fault flag");
        chkb(powerStageOn, 1'b0, "shut down");
        // seven ramps of four cycles: off for 27 more edges, back on at the 28th
        cyc(27);
        chkb(powerStageOn, 1'b0, "restart delay");
        cyc(1);
        chkb(powerStageOn, 1'b1, "restarted");
        converterEnable = 1'b0;
        clr();
        // latch off until cleared
        wr(8'h45, 16'h0080);
        dip();
        cyc(40);
        chkb(powerStageOn, 1'b0, "latched");
        clr();
        chkb(powerStageOn, 1'b1, "cleared");
        // ignore mode keeps running
        wr(8'h45, 16'h0000);
        converterEnable = 1'b0;
        clr();
        dip();
        chkb(uvFaultFlag, 1'b1, "ignored fault flag");
        chkb(smbAlert, 1'b1, "ignored alert");
        chkb(powerStageOn, 1'b1, "keeps running");
        // zero fault limit disables fault checking only
        wr(8'h44, 16'h0000);
        converterEnable = 1'b0;
        clr();
        dip();
        chkb(uvFaultFlag, 1'b0, "fault off");
        chkb(uvWarnFlag, 1'b1, "warn on");
        $display("test detection done");
        // save all drops the low fault bits
        converterEnable = 1'b0;
        wr(8'h44, 16'h0135);
        storeAll = 1'b1;
        cyc(1);
        storeAll = 1'b0;
        chkb(nvmStore, 1'b1, "store pulse");
        chkv(nvmFaultOut, 16'h0130, "stored fault");
        chkv({8'h00, nvmActionOut}, 16'h0007, "stored action");
        $display("test store done");
        // a write while the clock enable is low is not taken
        ce = 1'b0;
        wr(8'h43, 16'h0140);
        ce = 1'b1;
        rdc(8'h43, 16'h0143);
        chkb(commFlag, 1'b0, "frozen comm flag");
        $display("test clock enable done");
        end_sim();
    end
endmodule
`default_nettype wire
